//--- include/rapd_pkg.sv
// Shared constants and types for the line power-down controller
package rapd_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam int unsigned      CLK_MHZ      = 200;
   localparam int unsigned      INACT_TIME_S = 30;
   localparam longint unsigned  INACT_CYC    =
      longint'(INACT_TIME_S) * longint'(CLK_MHZ) * 64'd1000000;
   localparam int unsigned      BAND_TIME_US = 30;
   localparam int unsigned      BAND_CYC     = BAND_TIME_US * CLK_MHZ;
   localparam int               TMR_W        = 33;
   localparam int               BAND_W       = 16;
   localparam int               NUM_CH       = 2;

   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [7:0] ADR_STATUS   = 8'h00;
   localparam logic [7:0] ADR_IRQ_STAT = 8'h04;
   localparam logic [7:0] ADR_IRQ_MASK = 8'h08;
   localparam logic [7:0] ADR_CTRL     = 8'h0C;

   // Status fields
   localparam int ST_READY  = 0;
   localparam int ST_VALID  = 1;
   localparam int ST_DRV_ON = 2;
   localparam int ST_AUTO   = 3;
   localparam int ST_FORCE  = 4;
   localparam int ST_OFF    = 5;
   localparam int ST_SLEEP  = 6;
   localparam int ST_RAIL   = 7;
   localparam int ST_RCV_LO = 8;
   localparam int ST_DRV_LO = 10;

   // Event bits, shared by status and mask
   localparam int EV_DOWN     = 0;
   localparam int EV_WAKE     = 1;
   localparam int EV_VALID_UP = 2;
   localparam int EV_VALID_DN = 3;
   localparam int NUM_EV      = 4;
   localparam logic [NUM_EV-1:0] IRQ_MASK_RST = 4'h0;

   // Control fields
   localparam int CTRL_KICK = 0;

   typedef enum logic [1:0] {
      RAPD_MODE_AUTO,
      RAPD_MODE_FORCE,
      RAPD_MODE_OFF
   } rapd_mode_e;

   typedef enum logic {
      RAPD_ST_ON,
      RAPD_ST_SLEEP
   } rapd_state_e;

endpackage : rapd_pkg

//--- rtl/rapd_idle_timer.sv
// Inactivity timer that flags expiry after a fixed count of cycles
`timescale 1ns/10ps
module rapd_idle_timer #(
   parameter longint unsigned LIMIT = rapd_pkg::INACT_CYC
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic clr_i,
   output logic      expired_o
);
   import rapd_pkg::*;

   localparam logic [TMR_W-1:0] LIM = TMR_W'(LIMIT);

   logic [TMR_W-1:0] cnt_q;

   // Saturates so expiry stays asserted until something clears it
   always_ff @(posedge clk_i) begin
      if (rst_i || clr_i) begin
         cnt_q <= '0;
      end else if (cnt_q != LIM) begin
         cnt_q <= cnt_q + TMR_W'(1);
      end
   end

   assign expired_o = (cnt_q == LIM);

endmodule : rapd_idle_timer

//--- rtl/rapd_line_mon.sv
// Receiver monitor: pin sync, data pass-through, edges, level check
`timescale 1ns/10ps
module rapd_line_mon #(
   parameter int unsigned BAND_LIM = rapd_pkg::BAND_CYC
) (
   input  wire logic                        clk_i,
   input  wire logic                        rst_i,
   input  wire logic [rapd_pkg::NUM_CH-1:0] line_rcv_in_i,
   input  wire logic [rapd_pkg::NUM_CH-1:0] line_lvl_ok_i,
   input  wire logic [rapd_pkg::NUM_CH-1:0] line_in_band_i,
   output logic      [rapd_pkg::NUM_CH-1:0] rcv_logic_out_o,
   output logic                             rcv_edge_o,
   output logic                             valid_lvl_o
);
   import rapd_pkg::*;

   localparam logic [BAND_W-1:0] BLIM = BAND_W'(BAND_LIM);

   logic [NUM_CH-1:0] dat_m_q, dat_s_q, dat_d1_q;
   logic [NUM_CH-1:0] lvl_m_q, lvl_s_q;
   logic [NUM_CH-1:0] bnd_m_q, bnd_s_q;
   logic [NUM_CH-1:0] ch_ok;
   logic [NUM_CH-1:0] ch_edge;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_m_q  <= '0;
         dat_s_q  <= '0;
         dat_d1_q <= '0;
         lvl_m_q  <= '0;
         lvl_s_q  <= '0;
         bnd_m_q  <= '0;
         bnd_s_q  <= '0;
      end else begin
         dat_m_q  <= line_rcv_in_i;
         dat_s_q  <= dat_m_q;
         dat_d1_q <= dat_s_q;
         lvl_m_q  <= line_lvl_ok_i;
         lvl_s_q  <= lvl_m_q;
         bnd_m_q  <= line_in_band_i;
         bnd_s_q  <= bnd_m_q;
      end
   end

   // ****************************************
   // Per-channel in-band dwell
   // ****************************************
   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      logic [BAND_W-1:0] dwell_q;
      always_ff @(posedge clk_i) begin
         if (rst_i || !bnd_s_q[c]) begin
            dwell_q <= '0;
         end else if (dwell_q != BLIM) begin
            dwell_q <= dwell_q + BAND_W'(1);
         end
      end
      // A briefly idle line still counts as valid
      assign ch_ok[c]   = lvl_s_q[c] |
                          (bnd_s_q[c] & (dwell_q != BLIM));
      // Only a transition at a valid level counts as activity
      assign ch_edge[c] = (dat_s_q[c] ^ dat_d1_q[c]) & lvl_s_q[c];
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rcv_logic_out_o <= '0;
         valid_lvl_o     <= 1'b0;
      end else begin
         rcv_logic_out_o <= dat_s_q;
         valid_lvl_o     <= |ch_ok;
      end
   end

   assign rcv_edge_o = |ch_edge;

   valid_lvl_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (|lvl_s_q) |=> valid_lvl_o)
      else $error("valid flag low with a valid line level");

   rcv_pass_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 rcv_logic_out_o == $past(dat_s_q))
      else $error("receiver data not passed through");

endmodule : rapd_line_mon

//--- rtl/rapd_ctrl.sv
// Top of the line power-down controller with its register slave
//
// Overview of operation
// - Auto power-down only when stay-awake low, shutdown high.
// - 30 s without transitions powers drivers and pump down.
// - Any valid transition wakes from auto power-down.
// - Both force inputs high keep drivers and pump on.
// - Valid flag: line level valid or briefly idle.
// - Ready only with pump regulating; low when drivers off.
// - Receivers keep passing data while drivers are off.
// - Shutdown low forces power-down, overriding everything.
// - Ready rises only after negative rail is good.
`timescale 1ns/10ps
module rapd_ctrl #(
   parameter longint unsigned INACT_CYC_P = rapd_pkg::INACT_CYC,
   parameter int unsigned     BAND_CYC_P  = rapd_pkg::BAND_CYC
) (
   input  wire logic                        clk_i,
   input  wire logic                        rst_i,
   // Wishbone slave
   input  wire logic                        wb_cyc_i,
   input  wire logic                        wb_stb_i,
   input  wire logic                        wb_we_i,
   input  wire logic [7:0]                  wb_adr_i,
   input  wire logic [31:0]                 wb_dat_i,
   input  wire logic [3:0]                  wb_sel_i,
   output logic      [31:0]                 wb_dat_o,
   output logic                             wb_ack_o,
   output logic                             irq_o,
   // Power control pins
   input  wire logic                        stay_awake_in_i,
   input  wire logic                        shutdown_n_in_i,
   input  wire logic                        pump_rail_ok_i,
   output logic                             pump_en_o,
   output logic                             ready_o,
   output logic                             valid_lvl_o,
   // Drivers
   input  wire logic [rapd_pkg::NUM_CH-1:0] drv_data_i,
   output logic      [rapd_pkg::NUM_CH-1:0] drv_data_o,
   output logic                             drv_oe_o,
   // Receivers
   input  wire logic [rapd_pkg::NUM_CH-1:0] line_rcv_in_i,
   input  wire logic [rapd_pkg::NUM_CH-1:0] line_lvl_ok_i,
   input  wire logic [rapd_pkg::NUM_CH-1:0] line_in_band_i,
   output logic      [rapd_pkg::NUM_CH-1:0] rcv_logic_out_o
);
   import rapd_pkg::*;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic              stay_m_q, stay_s_q;
   logic              shut_m_q, shut_s_q;
   logic              rail_m_q, rail_s_q;
   logic [NUM_CH-1:0] din_m_q, din_s_q, din_d1_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stay_m_q <= 1'b0;
         stay_s_q <= 1'b0;
         shut_m_q <= 1'b0;
         shut_s_q <= 1'b0;
         rail_m_q <= 1'b0;
         rail_s_q <= 1'b0;
         din_m_q  <= '0;
         din_s_q  <= '0;
         din_d1_q <= '0;
      end else begin
         stay_m_q <= stay_awake_in_i;
         stay_s_q <= stay_m_q;
         shut_m_q <= shutdown_n_in_i;
         shut_s_q <= shut_m_q;
         rail_m_q <= pump_rail_ok_i;
         rail_s_q <= rail_m_q;
         din_m_q  <= drv_data_i;
         din_s_q  <= din_m_q;
         din_d1_q <= din_s_q;
      end
   end

   // ****************************************
   // Receiver monitor and idle timer
   // ****************************************
   logic rcv_edge;
   logic valid_lvl;
   logic expired;
   logic idle_clr;
   logic activity;
   logic kick_q;

   rapd_line_mon #(
      .BAND_LIM       (BAND_CYC_P)
   ) u_line_mon (
      .clk_i          (clk_i),
      .rst_i          (rst_i),
      .line_rcv_in_i  (line_rcv_in_i),
      .line_lvl_ok_i  (line_lvl_ok_i),
      .line_in_band_i (line_in_band_i),
      .rcv_logic_out_o(rcv_logic_out_o),
      .rcv_edge_o     (rcv_edge),
      .valid_lvl_o    (valid_lvl)
   );

   // Driver input transitions count as activity just like line edges
   assign activity = rcv_edge | (|(din_s_q ^ din_d1_q)) | kick_q;

   rapd_idle_timer #(
      .LIMIT    (INACT_CYC_P)
   ) u_idle (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .clr_i    (idle_clr),
      .expired_o(expired)
   );

   // ****************************************
   // Operating mode and power state
   // ****************************************
   rapd_mode_e  mode;
   rapd_state_e state_q, state_d;
   logic        drv_on_q, drv_on_d;
   logic        ready_q;

   always_comb begin
      if (!shut_s_q) begin
         mode = RAPD_MODE_OFF;
      end else if (stay_s_q) begin
         mode = RAPD_MODE_FORCE;
      end else begin
         mode = RAPD_MODE_AUTO;
      end
   end

   // The timer only runs in automatic mode, so leaving it restarts 30 s
   assign idle_clr = activity | (mode != RAPD_MODE_AUTO);

   always_comb begin
      state_d = state_q;
      if (mode != RAPD_MODE_AUTO) begin
         state_d = RAPD_ST_ON;
      end else begin
         unique case (state_q)
            RAPD_ST_ON: begin
               if (expired && !activity) begin
                  state_d = RAPD_ST_SLEEP;
               end
            end
            RAPD_ST_SLEEP: begin
               if (activity) begin
                  state_d = RAPD_ST_ON;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= RAPD_ST_ON;
      end else begin
         state_q <= state_d;
      end
   end

   // With both force pins tied to the valid flag, a lost level lands in
   // the shutdown branch and a present one in the forced-on branch
   always_comb begin
      unique case (mode)
         RAPD_MODE_OFF:   drv_on_d = 1'b0;
         RAPD_MODE_FORCE: drv_on_d = 1'b1;
         RAPD_MODE_AUTO:  drv_on_d = (state_d == RAPD_ST_ON);
         default:         drv_on_d = 1'b0;
      endcase
   end

   // Drivers start off until the first mode decision after reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         drv_on_q   <= 1'b0;
         drv_data_o <= '0;
      end else begin
         drv_on_q   <= drv_on_d;
         drv_data_o <= din_s_q;
      end
   end

   // Ready follows the rail comparator but drops with the drivers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ready_q <= 1'b0;
      end else begin
         ready_q <= drv_on_d & rail_s_q;
      end
   end

   assign pump_en_o   = drv_on_q;
   assign drv_oe_o    = drv_on_q;
   assign ready_o     = ready_q;
   assign valid_lvl_o = valid_lvl;

   // ****************************************
   // Wishbone slave
   // ****************************************
   logic              req;
   logic              wr_en;
   logic              ack_q;
   logic [31:0]       rdat_q;
   logic [31:0]       rdat;
   logic [NUM_EV-1:0] irq_stat_q;
   logic [NUM_EV-1:0] irq_mask_q;
   logic [NUM_EV-1:0] events;
   logic [NUM_EV-1:0] w1c;
   logic              valid_d1_q;

   assign req   = wb_cyc_i & wb_stb_i & ~ack_q;
   assign wr_en = req & wb_we_i & wb_sel_i[0];

   always_comb begin
      rdat = 32'h0000_0000;
      unique case (wb_adr_i)
         ADR_STATUS: begin
            rdat[ST_READY]  = ready_q;
            rdat[ST_VALID]  = valid_lvl;
            rdat[ST_DRV_ON] = drv_on_q;
            rdat[ST_AUTO]   = (mode == RAPD_MODE_AUTO);
            rdat[ST_FORCE]  = (mode == RAPD_MODE_FORCE);
            rdat[ST_OFF]    = (mode == RAPD_MODE_OFF);
            rdat[ST_SLEEP]  = (state_q == RAPD_ST_SLEEP);
            rdat[ST_RAIL]   = rail_s_q;
            rdat[ST_RCV_LO +: NUM_CH] = rcv_logic_out_o;
            rdat[ST_DRV_LO +: NUM_CH] = din_s_q;
         end
         ADR_IRQ_STAT: rdat[NUM_EV-1:0] = irq_stat_q;
         ADR_IRQ_MASK: rdat[NUM_EV-1:0] = irq_mask_q;
         default:      rdat = 32'h0000_0000;
      endcase
   end

   // One wait state: ack comes the cycle after the request is seen
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q  <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else begin
         ack_q  <= req;
         if (req) begin
            rdat_q <= rdat;
         end
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   // Kick is a one-cycle pulse that restarts the idle timer and wakes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         kick_q <= 1'b0;
      end else begin
         kick_q <= wr_en && (wb_adr_i == ADR_CTRL) && wb_dat_i[CTRL_KICK];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_mask_q <= IRQ_MASK_RST;
      end else if (wr_en && (wb_adr_i == ADR_IRQ_MASK)) begin
         irq_mask_q <= wb_dat_i[NUM_EV-1:0];
      end
   end

   // ****************************************
   // Interrupts
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         valid_d1_q <= 1'b0;
      end else begin
         valid_d1_q <= valid_lvl;
      end
   end

   assign events[EV_DOWN]     = drv_on_q & ~drv_on_d;
   assign events[EV_WAKE]     = ~drv_on_q & drv_on_d;
   assign events[EV_VALID_UP] = valid_lvl & ~valid_d1_q;
   assign events[EV_VALID_DN] = ~valid_lvl & valid_d1_q;

   assign w1c = (wr_en && (wb_adr_i == ADR_IRQ_STAT)) ?
                wb_dat_i[NUM_EV-1:0] : '0;

   // A new event in the clearing cycle survives the clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat_q <= '0;
      end else begin
         irq_stat_q <= (irq_stat_q & ~w1c) | events;
      end
   end

   assign irq_o = |(irq_stat_q & irq_mask_q);

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence idle_expire_s;
      (mode == RAPD_MODE_AUTO) && (state_q == RAPD_ST_ON) &&
      expired && !activity;
   endsequence

   sequence wake_seen_s;
      (mode == RAPD_MODE_AUTO) && (state_q == RAPD_ST_SLEEP) && activity;
   endsequence

   auto_only_sleep_a: assert property (
      (state_q == RAPD_ST_ON) ##1 (state_q == RAPD_ST_SLEEP)
      |-> $past(mode) == RAPD_MODE_AUTO)
      else $error("power-down outside automatic mode");

   idle_down_a: assert property (
      idle_expire_s |=> (state_q == RAPD_ST_SLEEP) && !drv_oe_o
      && !pump_en_o)
      else $error("no power-down after inactivity");

   wake_up_a: assert property (
      wake_seen_s |=> drv_oe_o && pump_en_o)
      else $error("activity did not wake the drivers");

   force_on_a: assert property (
      (mode == RAPD_MODE_FORCE) |=> drv_oe_o && pump_en_o)
      else $error("drivers off while forced on");

   ready_off_a: assert property (
      !drv_oe_o |-> !ready_o)
      else $error("ready high with drivers off");

   shut_prio_a: assert property (
      !shut_s_q |=> !drv_oe_o && !pump_en_o && !ready_o)
      else $error("shutdown did not power down");

   ready_rail_a: assert property (
      $rose(ready_o) |-> $past(rail_s_q) && drv_oe_o)
      else $error("ready rose without a good rail");

   tied_valid_a: assert property (
      (!stay_s_q && !shut_s_q) [*2] |-> !drv_oe_o)
      else $error("drivers on with both force pins low");

   irq_keep_a: assert property (
      (|events) |=> (irq_stat_q & $past(events)) == $past(events))
      else $error("event lost in status");

endmodule : rapd_ctrl

//--- tb/rapd_line_peer.sv
// Line-side peer model: serial cable with a peripheral on the far end
`timescale 1ns/10ps
module rapd_line_peer (
   input  wire logic                        clk_i,
   input  wire logic                        conn_i,
   input  wire logic                        mid_i,
   input  wire logic [rapd_pkg::NUM_CH-1:0] data_i,
   output logic      [rapd_pkg::NUM_CH-1:0] line_rcv_in_o,
   output logic      [rapd_pkg::NUM_CH-1:0] line_lvl_ok_o,
   output logic      [rapd_pkg::NUM_CH-1:0] line_in_band_o
);
   import rapd_pkg::*;

   // ****************************************
   // Line levels
   // ****************************************
   // Unplugged: no valid level, and the floating data flips every cycle
   // so that a stale value can never pass for real traffic
   always_ff @(posedge clk_i) begin
      if (conn_i) begin
         line_rcv_in_o  <= data_i;
         line_lvl_ok_o  <= '1;
         line_in_band_o <= '0;
      end else begin
         line_rcv_in_o  <= (line_rcv_in_o === 2'h1) ? 2'h2 : 2'h1;
         line_lvl_ok_o  <= '0;
         line_in_band_o <= mid_i ? '0 : '1;
      end
   end
endmodule : rapd_line_peer

//--- tb/rapd_ctrl_test.sv
// Self-checking testbench for the line power-down controller
`timescale 1ns/10ps
module rapd_ctrl_test;
   import rapd_pkg::*;

   logic              clk_i;
   logic              rst_i;
   logic              cyc, stb, we;
   logic [7:0]        adr;
   logic [31:0]       wdat, rdat;
   logic [3:0]        sel;
   logic [31:0]       wb_dat_o;
   logic              wb_ack_o, irq_o;
   logic              stay, shut_n, rail, tie;
   logic              pump_en_o, ready_o, valid_lvl_o, drv_oe_o;
   logic [NUM_CH-1:0] drv_in, drv_out, rcv_out, pdata, line_rcv_in, lok, band;
   logic              conn, mid;
   int                n_fail, total_checks, cycles;

   rapd_ctrl #(.INACT_CYC_P(200), .BAND_CYC_P(20)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
      .stay_awake_in_i(stay), .shutdown_n_in_i(shut_n),
      .pump_rail_ok_i(rail), .pump_en_o(pump_en_o), .ready_o(ready_o),
      .valid_lvl_o(valid_lvl_o), .drv_data_i(drv_in), .drv_data_o(drv_out),
      .drv_oe_o(drv_oe_o), .line_rcv_in_i(line_rcv_in), .line_lvl_ok_i(lok),
      .line_in_band_i(band), .rcv_logic_out_o(rcv_out));

   rapd_line_peer peer (
      .clk_i(clk_i), .conn_i(conn), .mid_i(mid), .data_i(pdata),
      .line_rcv_in_o(line_rcv_in), .line_lvl_ok_o(lok), .line_in_band_o(band));

   // ****************************************
   // Clock, timeout, pin tie-back
   // ****************************************
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         print_verdict();
      end
   end

   // Both force pins follow the valid flag, as a board would wire them
   always @(posedge clk_i) begin
      if (tie) begin
         stay   <= valid_lvl_o;
         shut_n <= valid_lvl_o;
      end
   end

   // ****************************************
   // Tasks
   // ****************************************
   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : print_verdict

   task automatic chk(input string name, input logic [31:0] exp,
                      input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask : wait_cyc

   // Classic single cycle; waits on ack with no assumed latency
   task automatic wb_xfer(input logic w, input logic [7:0] a,
                          input logic [31:0] d);
      @(posedge clk_i);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      sel  <= 4'hF;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rdat = wb_dat_o;
      cyc  <= 1'b0;
      stb  <= 1'b0;
      we   <= 1'b0;
   endtask : wb_xfer

   task automatic wb_rd(input string name, input logic [7:0] a,
                        input logic [31:0] exp);
      wb_xfer(1'b0, a, 32'h0);
      chk(name, exp, rdat);
   endtask : wb_rd

   task automatic pwr(input string name, input logic [31:0] exp);
      chk(name, exp, {29'h0, pump_en_o, drv_oe_o, ready_o});
   endtask : pwr

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      {cyc, stb, we, tie, mid, rst_i} = 6'h01;
      {adr, wdat, sel} = '0;
      {stay, shut_n, rail, conn} = 4'hF;
      drv_in = '0;
      pdata = '0;
      n_fail = 0;
      total_checks = 0;
      cycles = 0;
      wait_cyc(4);
      pwr("reset pwr", 32'h0);
      wait_cyc(1);
      rst_i <= 1'b0;
      wb_rd("mask rst", ADR_IRQ_MASK, 32'h0);
      wb_xfer(1'b1, 8'h10, 32'hFFFF_FFFF);
      wb_rd("unmapped", 8'h10, 32'h0);
      wb_rd("ctrl rd", ADR_CTRL, 32'h0);
      $display("test registers done");

      wait_cyc(300);
      pwr("force on", 32'h7);
      chk("valid on", 32'h1, valid_lvl_o);
      rail <= 1'b0;
      wait_cyc(5);
      pwr("rail low", 32'h6);
      rail <= 1'b1;
      wait_cyc(5);
      pwr("rail back", 32'h7);
      wb_rd("status on", ADR_STATUS, 32'h0000_0097);
      $display("test force-on done");

      wb_xfer(1'b1, ADR_IRQ_STAT, 32'hF);
      wb_xfer(1'b1, ADR_IRQ_MASK, 32'h1);
      wb_rd("mask rd", ADR_IRQ_MASK, 32'h1);
      stay <= 1'b0;
      wait_cyc(100);
      pwr("auto early", 32'h7);
      chk("irq idle", 32'h0, irq_o);
      // A kick restarts the idle count, so the first expiry must not hit
      wb_xfer(1'b1, ADR_CTRL, 32'h1);
      wait_cyc(150);
      pwr("kick keeps", 32'h7);
      wait_cyc(100);
      pwr("auto down", 32'h0);
      chk("irq down", 32'h1, irq_o);
      wb_rd("irq stat", ADR_IRQ_STAT, 32'h1);
      wb_rd("status sleep", ADR_STATUS, 32'h0000_00CA);
      wb_xfer(1'b1, ADR_IRQ_STAT, 32'h1);
      wait_cyc(1);
      chk("irq clr", 32'h0, irq_o);
      conn <= 1'b0;
      wait_cyc(40);
      pwr("noise", 32'h0);
      drv_in <= 2'h1;
      wait_cyc(6);
      pwr("wake", 32'h7);
      chk("drv data", 32'h1, drv_out);
      $display("test auto done");

      stay <= 1'b1;
      mid <= 1'b1;
      wait_cyc(5);
      chk("mid level", 32'h0, valid_lvl_o);
      // Entering the idle band restarts the dwell count
      mid <= 1'b0;
      wait_cyc(10);
      chk("band short", 32'h1, valid_lvl_o);
      wait_cyc(30);
      chk("band long", 32'h0, valid_lvl_o);
      conn <= 1'b1;
      wait_cyc(5);
      chk("reconnect", 32'h1, valid_lvl_o);
      $display("test valid done");

      shut_n <= 1'b0;
      pdata <= 2'h2;
      wait_cyc(6);
      pwr("shutdown", 32'h0);
      chk("rcv pass", 32'h2, rcv_out);
      drv_in <= 2'h2;
      wait_cyc(6);
      pwr("shut activity", 32'h0);
      shut_n <= 1'b1;
      wait_cyc(5);
      pwr("shut release", 32'h7);
      $display("test shutdown done");

      tie <= 1'b1;
      conn <= 1'b0;
      mid <= 1'b0;
      wait_cyc(40);
      pwr("tied invalid", 32'h0);
      conn <= 1'b1;
      wait_cyc(10);
      pwr("tied valid", 32'h7);
      $display("test tied pins done");
      print_verdict();
   end
endmodule : rapd_ctrl_test
